//--- verilog/pwt_timer.sv
// PWM compare timer with classic Wishbone register slave and match interrupt.
//
// What this block does
// [R1] Period register sets cycle, duty register width.
// [R2] Software keeps duty below period, both 8-bit.
// [R3] Enable bit starts counting; period compared first.
// [R4] Period match clears counter, requests, output active.
// [R5] Duty match: output inactive, compare period again.
// [R6] Cycle N+1 clocks, active width M+1.
// [R7] One count clock masked at start, output inactive.
// [R8] Stopping forces request and output inactive.
// [R9] Duty writes while running go to latch.
// [R10] Latched duty moves in on old-duty match.
// [R11] Transfer needs three count clocks after write.
// [R12] Match on new duty ends the pulse.
// [R13] Software rewrites duty while stopped, before every restart.
// [R14] Enable zero stops and clears the counter.
// [R15] Clock select picks prescaled or slow-oscillator clock.
// [R16] Mode bits not rewritten while enabled.
// [R17] Period not rewritten while counting.
// [R18] Match request lasts one count clock period.
// [R19] Output disabled holds inactive level, timer runs.
`timescale 1ns/100ps

`include "pwt_defs.svh"

module pwt_timer (
    input  wire logic       mclk_i,
    input  wire logic       rst_n_i,
    input  wire logic       wb_cyc_i,
    input  wire logic       wb_stb_i,
    input  wire logic       wb_we_i,
    input  wire logic [7:0] wb_adr_i,
    input  wire logic [3:0] wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic            wb_ack_o,
    input  wire logic       slow_osc_clk_i,
    output logic            pulse_output_pin_o,
    output logic            period_match_irq_o,
    output logic            irq_o
);
    import pwt_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // Register file and bus slave.

    pwt_mode_t  mode_q, mode_d;
    logic [7:0] period_q, period_d;
    logic [7:0] duty_lat_q, duty_lat_d;
    logic [1:0] stat_q, stat_d;
    logic [1:0] mask_q, mask_d;
    logic [31:0] rdat_q, rdat_d;
    logic       ack_q, ack_d;
    logic       bus_req;
    logic       bus_wr;
    logic       duty_wr;
    logic       duty_ev;
    logic       period_ev;
    logic [7:0] cnt_q;

    function automatic logic hit(input logic [7:0] adr, input logic [7:0] reg_adr);
        hit = (adr == reg_adr);
    endfunction

    assign bus_req = wb_cyc_i & wb_stb_i & ~ack_q;
    assign bus_wr  = bus_req & wb_we_i & wb_sel_i[0];
    assign duty_wr = bus_wr & hit(wb_adr_i, `PWT_ADR_DUTY);

    always_comb begin
        mode_d     = mode_q;
        period_d   = period_q;
        duty_lat_d = duty_lat_q;
        mask_d     = mask_q;
        stat_d     = stat_q;
        rdat_d     = rdat_q;
        ack_d      = bus_req;
        if (bus_req && !wb_we_i) begin
            rdat_d = 32'h0000_0000;
            if (hit(wb_adr_i, `PWT_ADR_MODE)) begin
                rdat_d[7:0] = mode_q;
            end
            if (hit(wb_adr_i, `PWT_ADR_PERIOD)) begin
                rdat_d[7:0] = period_q;
            end
            if (hit(wb_adr_i, `PWT_ADR_DUTY)) begin
                rdat_d[7:0] = duty_lat_q;
            end
            if (hit(wb_adr_i, `PWT_ADR_STATUS)) begin
                rdat_d[1:0] = stat_q;
                stat_d      = `PWT_RST_STAT;
            end
            if (hit(wb_adr_i, `PWT_ADR_MASK)) begin
                rdat_d[1:0] = mask_q;
            end
            if (hit(wb_adr_i, `PWT_ADR_COUNT)) begin
                rdat_d[7:0] = cnt_q;
            end
        end
        if (bus_wr) begin
            if (hit(wb_adr_i, `PWT_ADR_MODE)) begin
                mode_d = wb_dat_i[7:0];
            end
            // The period register is only meant to change while stopped. [R17]
            if (hit(wb_adr_i, `PWT_ADR_PERIOD)) begin
                period_d = wb_dat_i[7:0];
            end
            if (duty_wr) begin
                duty_lat_d = wb_dat_i[7:0];                                       // [R9]
            end
            if (hit(wb_adr_i, `PWT_ADR_MASK)) begin
                mask_d = wb_dat_i[1:0];
            end
        end
        // A new event wins over a clearing read in the same cycle.
        if (period_ev) begin
            stat_d = stat_d | `PWT_STAT_PERIOD;
        end
        if (duty_ev) begin
            stat_d = stat_d | `PWT_STAT_DUTY;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            mode_q     <= `PWT_RST_BYTE;
            period_q   <= `PWT_RST_BYTE;
            duty_lat_q <= `PWT_RST_BYTE;
            mask_q     <= `PWT_RST_STAT;
            stat_q     <= `PWT_RST_STAT;
            rdat_q     <= 32'h0000_0000;
            ack_q      <= 1'b0;
        end else begin
            mode_q     <= mode_d;
            period_q   <= period_d;
            duty_lat_q <= duty_lat_d;
            mask_q     <= mask_d;
            stat_q     <= stat_d;
            rdat_q     <= rdat_d;
            ack_q      <= ack_d;
        end
    end

    assign wb_dat_o = rdat_q;
    assign wb_ack_o = ack_q;
    assign irq_o    = |(stat_q & mask_q);

    ////////////////////////////////////////////////////////////////////////////////
    // Count clock selection.

    logic [11:0] pre_q, pre_d;
    logic [6:0]  rl_div_q, rl_div_d;
    logic        rl_s1_q, rl_s2_q, rl_s3_q;
    logic        rl_edge;
    logic        tick;

    assign rl_edge = rl_s2_q & ~rl_s3_q;

    function automatic logic sel_tick(input logic [2:0] cks, input logic [11:0] pre,
                                      input logic [6:0] rl_div, input logic rl_e);
        case (cks)
            `PWT_CKS_DIV1:    sel_tick = 1'b1;
            `PWT_CKS_DIV4:    sel_tick = (pre[1:0] == `PWT_PRE_M4);
            `PWT_CKS_DIV16:   sel_tick = (pre[3:0] == `PWT_PRE_M16);
            `PWT_CKS_DIV64:   sel_tick = (pre[5:0] == `PWT_PRE_M64);
            `PWT_CKS_DIV4096: sel_tick = (pre == `PWT_PRE_M4096);
            `PWT_CKS_RL128:   sel_tick = rl_e && (rl_div == `PWT_RL_M128);
            default:          sel_tick = 1'b0;
        endcase
    endfunction

    // Prohibited select codes simply never produce a count clock. [R15]
    assign tick = sel_tick(mode_q.cks, pre_q, rl_div_q, rl_edge);                  // [R15]

    always_comb begin
        pre_d    = pre_q + 12'h001;
        rl_div_d = rl_edge ? rl_div_q + 7'h01 : rl_div_q;
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            pre_q    <= 12'h000;
            rl_div_q <= 7'h00;
            rl_s1_q  <= 1'b0;
            rl_s2_q  <= 1'b0;
            rl_s3_q  <= 1'b0;
        end else begin
            pre_q    <= pre_d;
            rl_div_q <= rl_div_d;
            rl_s1_q  <= slow_osc_clk_i;
            rl_s2_q  <= rl_s1_q;
            rl_s3_q  <= rl_s2_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Counter, compare phase, output and match request.

    logic [7:0] cnt_d;
    logic [7:0] duty_q, duty_d;
    logic       pend_q, pend_d;
    logic [1:0] age_q, age_d;
    logic       started_q, started_d;
    logic       toggle_q, toggle_d;
    pwt_phase_t phase_q, phase_d;
    pwt_out_t   out_q, out_d;
    logic       pin_q, pin_d;
    logic       is_pwm;
    logic       per_hit;
    logic       duty_hit;

    assign is_pwm   = (mode_q.md == `PWT_MD_PWM);
    assign per_hit  = started_q && (cnt_q == period_q) && (!is_pwm || phase_q == PWT_PH_PERIOD);
    assign duty_hit = started_q && is_pwm && (phase_q == PWT_PH_DUTY) && (cnt_q == duty_q);
    assign period_ev = tick && mode_q.en && per_hit;
    assign duty_ev   = tick && mode_q.en && duty_hit;

    always_comb begin
        cnt_d     = cnt_q;
        duty_d    = duty_q;
        pend_d    = pend_q;
        age_d     = age_q;
        started_d = started_q;
        toggle_d  = toggle_q;
        phase_d   = phase_q;
        out_d     = out_q;
        if (!mode_q.en) begin
            cnt_d     = 8'h00;                                                    // [R14]
            started_d = 1'b0;
            toggle_d  = 1'b0;
            phase_d   = PWT_PH_PERIOD;                                            // [R3]
            out_d     = '0;                                                       // [R8]
            pend_d    = 1'b0;
        end else if (tick) begin
            out_d.irq = 1'b0;                                                     // [R18]
            if (!started_q) begin
                started_d = 1'b1;                                                 // [R7]
            end else if (per_hit) begin
                cnt_d      = 8'h00;                                               // [R4]
                out_d.irq  = 1'b1;                                                // [R4]
                toggle_d   = ~toggle_q;
                if (is_pwm) begin
                    out_d.active = 1'b1;                                          // [R4]
                    phase_d      = PWT_PH_DUTY;                                   // [R1]
                end else begin
                    out_d.active = ~toggle_q;
                end
            end else if (duty_hit) begin
                // Counter keeps running to the period, so width is M+1 of N+1. [R6]
                cnt_d        = cnt_q + 8'h01;                                     // [R5]
                out_d.active = 1'b0;                                              // [R12]
                phase_d      = PWT_PH_PERIOD;                                     // [R5]
                if (pend_q && age_q == `PWT_XFER_TICKS) begin
                    duty_d = duty_lat_q;                                          // [R10]
                    pend_d = 1'b0;
                end
            end else begin
                cnt_d = cnt_q + 8'h01;
            end
            if (pend_q && age_q != `PWT_XFER_TICKS) begin
                age_d = age_q + 2'h1;                                             // [R11]
            end
        end
        if (duty_wr) begin
            // A write restarts the settling count, so a near match will not transfer. [R11]
            age_d  = 2'h0;
            pend_d = mode_q.en;                                                   // [R9]
            if (!mode_q.en) begin
                duty_d = wb_dat_i[7:0];                                           // [R13]
            end
        end
        // Pin drives inactive level when disabled; counting continues. [R19]
        pin_d = mode_q.toen ? (out_d.active ^ mode_q.tolev) : mode_q.tolev;       // [R7]
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            cnt_q     <= 8'h00;
            duty_q    <= `PWT_RST_BYTE;
            pend_q    <= 1'b0;
            age_q     <= 2'h0;
            started_q <= 1'b0;
            toggle_q  <= 1'b0;
            phase_q   <= PWT_PH_PERIOD;
            out_q     <= '0;
            pin_q     <= 1'b0;
        end else begin
            cnt_q     <= cnt_d;
            duty_q    <= duty_d;
            pend_q    <= pend_d;
            age_q     <= age_d;
            started_q <= started_d;
            toggle_q  <= toggle_d;
            phase_q   <= phase_d;
            out_q     <= out_d;
            pin_q     <= pin_d;
        end
    end

    assign pulse_output_pin_o = pin_q;
    assign period_match_irq_o = out_q.irq;                                        // [R8]

endmodule // pwt_timer

//--- verilog/pwt_defs.svh
// Register offsets, codes, reset values and counts of the PWM compare timer.
`ifndef PWT_DEFS_SVH
`define PWT_DEFS_SVH

////////////////////////////////////////////////////////////////////////////////
`define PWT_ADR_MODE      8'h00
`define PWT_ADR_PERIOD    8'h04
`define PWT_ADR_DUTY      8'h08
`define PWT_ADR_STATUS    8'h0C
`define PWT_ADR_MASK      8'h10
`define PWT_ADR_COUNT     8'h14

`define PWT_RST_BYTE      8'h00
`define PWT_RST_STAT      2'h0
`define PWT_STAT_PERIOD   2'h1
`define PWT_STAT_DUTY     2'h2

////////////////////////////////////////////////////////////////////////////////
`define PWT_CKS_DIV1      3'h0
`define PWT_CKS_DIV4      3'h1
`define PWT_CKS_DIV16     3'h2
`define PWT_CKS_DIV64     3'h3
`define PWT_CKS_DIV4096   3'h4
`define PWT_CKS_RL128     3'h5

`define PWT_MD_PWM        2'h2

`define PWT_PRE_M4        2'h3
`define PWT_PRE_M16       4'hF
`define PWT_PRE_M64       6'h3F
`define PWT_PRE_M4096     12'hFFF
`define PWT_RL_M128       7'h7F

`define PWT_XFER_TICKS    2'h3

`endif

//--- verilog/pwt_pkg.sv
// Types shared by the PWM compare timer.
package pwt_pkg;

    typedef struct packed {
        logic       en;
        logic [2:0] cks;
        logic [1:0] md;
        logic       tolev;
        logic       toen;
    } pwt_mode_t;

    typedef enum logic {
        PWT_PH_PERIOD,
        PWT_PH_DUTY
    } pwt_phase_t;

    typedef struct packed {
        logic       active;
        logic       irq;
    } pwt_out_t;

endpackage

//--- testbench/pwt_timer_checker.sv
// Port-level assertions for the PWM compare timer.
`timescale 1ns/100ps
`include "pwt_defs.svh"
module pwt_timer_checker (
    input wire logic        mclk_i,
    input wire logic        rst_n_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        pulse_output_pin_o,
    input wire logic        period_match_irq_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);
    a_ack_follows: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not acknowledged");
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("acknowledge longer than one cycle");
    a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("acknowledge without request");
    a_dat_hold: assert property (!$stable(wb_dat_o) |-> wb_ack_o && !wb_we_i)
        else $error("read data moved outside a read");
    a_upper_zero: assert property (wb_ack_o && !wb_we_i |-> wb_dat_o[31:8] == 24'h00_0000)
        else $error("upper read bits not zero");
    a_unmapped_zero: assert property (wb_ack_o && !wb_we_i && wb_adr_i > `PWT_ADR_COUNT
        |-> wb_dat_o == 32'h0000_0000) else $error("unmapped read not zero");
    a_status_bits: assert property (wb_ack_o && !wb_we_i && wb_adr_i == `PWT_ADR_STATUS
        |-> wb_dat_o[7:2] == 6'h00) else $error("status spare bits set");
    a_stop_quiet: assert property (wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == `PWT_ADR_MODE
        && !wb_dat_i[7] |=> ##1 (!period_match_irq_o && pulse_output_pin_o == $past(wb_dat_i[1], 2)))
        else $error("outputs not inactive after stop");
endmodule // pwt_timer_checker

bind pwt_timer pwt_timer_checker u_chk (.mclk_i, .rst_n_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .pulse_output_pin_o, .period_match_irq_o);

//--- testbench/pwt_load.sv
// Load on the pulse pin that measures cycle length and high time in clock cycles.
`timescale 1ns/100ps
module pwt_load (
    input  wire logic        mclk_i,
    input  wire logic        pin_i,
    output logic      [15:0] high_len_o,
    output logic      [15:0] cycle_len_o
);
    logic        pin_q;
    logic [15:0] rise_cnt;
    // One counter serves both widths because both are taken from the last rising edge.
    always_ff @(posedge mclk_i) begin
        pin_q <= pin_i;
        rise_cnt <= (pin_i && !pin_q) ? 16'h0001 : rise_cnt + 16'h0001;
        if (pin_i && !pin_q) cycle_len_o <= rise_cnt;
        if (!pin_i && pin_q) high_len_o <= rise_cnt;
    end
endmodule // pwt_load

//--- testbench/test_pwt_timer.sv
// Self-checking bench for the PWM compare timer.
`timescale 1ns/100ps
`include "pwt_defs.svh"
module test_pwt_timer;
    import pwt_pkg::*;
    logic        mclk_i, rst_n_i, wb_cyc_i, wb_stb_i, wb_we_i, slow_osc_clk_i;
    logic [7:0]  wb_adr_i;
    logic [3:0]  wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o, rd_dat;
    logic        wb_ack_o, pulse_output_pin_o, period_match_irq_o, irq_o;
    logic [15:0] hi_len, cyc_len;
    int          err_count, comparisons;
    pwt_timer DUT (.mclk_i, .rst_n_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
        .wb_dat_o, .wb_ack_o, .slow_osc_clk_i, .pulse_output_pin_o, .period_match_irq_o, .irq_o);
    pwt_load u_load (.mclk_i, .pin_i(pulse_output_pin_o), .high_len_o(hi_len), .cycle_len_o(cyc_len));
    initial begin
        mclk_i = 1'b0;
        forever #50 mclk_i = ~mclk_i;
    end
    initial begin
        slow_osc_clk_i = 1'b0;
        forever #200 slow_osc_clk_i = ~slow_osc_clk_i;
    end
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_dat_i <= d;
        do begin
            @(posedge mclk_i);
        end while (wb_ack_o !== 1'b1);
        rd_dat = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    task automatic set_mode(input logic en, input logic [2:0] cks, input logic lev, input logic oe);
        pwt_mode_t m;
        m = '{en, cks, `PWT_MD_PWM, lev, oe};
        bus(1'b1, `PWT_ADR_MODE, {24'h00_0000, m});
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge mclk_i);
        @(negedge mclk_i);
    endtask
    task automatic t_basic;
        bus(1'b1, `PWT_ADR_PERIOD, 32'h0000_0009);
        bus(1'b1, `PWT_ADR_DUTY, 32'h0000_0003);
        set_mode(1'b1, `PWT_CKS_DIV1, 1'b0, 1'b1);
        @(negedge mclk_i);
        check("pin at start", pulse_output_pin_o, 32'h0000_0000);
        settle(40);
        check("cycle", cyc_len, 32'h0000_000A);
        check("active", hi_len, 32'h0000_0004);
        bus(1'b0, `PWT_ADR_STATUS, 32'h0000_0000);
        check("status", rd_dat, 32'h0000_0003);
    endtask
    task automatic t_duty;
        int n_hi;
        n_hi = 0;
        // The write lands two counts before the old-duty match, so that match must not transfer.
        @(posedge pulse_output_pin_o);
        bus(1'b1, `PWT_ADR_DUTY, 32'h0000_0006);
        bus(1'b0, `PWT_ADR_DUTY, 32'h0000_0000);
        check("duty latch", rd_dat, 32'h0000_0006);
        settle(13);
        check("late write", hi_len, 32'h0000_0004);
        settle(40);
        check("new active", hi_len, 32'h0000_0007);
        check("same cycle", cyc_len, 32'h0000_000A);
        repeat (30) begin
            @(negedge mclk_i);
            n_hi += period_match_irq_o;
        end
        check("irq cycles", n_hi, 32'h0000_0003);
    endtask
    task automatic t_irq;
        bus(1'b1, `PWT_ADR_MASK, 32'h0000_0001);
        settle(12);
        check("irq on", irq_o, 32'h0000_0001);
        set_mode(1'b0, `PWT_CKS_DIV1, 1'b0, 1'b1);
        settle(2);
        check("pin stop", pulse_output_pin_o, 32'h0000_0000);
        check("req stop", period_match_irq_o, 32'h0000_0000);
        bus(1'b0, `PWT_ADR_COUNT, 32'h0000_0000);
        check("count stop", rd_dat, 32'h0000_0000);
        bus(1'b0, `PWT_ADR_STATUS, 32'h0000_0000);
        settle(1);
        check("irq off", irq_o, 32'h0000_0000);
        bus(1'b0, 8'h20, 32'h0000_0000);
        check("unmapped", rd_dat, 32'h0000_0000);
        bus(1'b0, `PWT_ADR_PERIOD, 32'h0000_0000);
        check("period", rd_dat, 32'h0000_0009);
    endtask
    task automatic t_slow;
        int n_hi;
        int n_pin;
        n_hi = 0;
        n_pin = 0;
        bus(1'b1, `PWT_ADR_DUTY, 32'h0000_0003);
        set_mode(1'b1, `PWT_CKS_DIV4, 1'b1, 1'b0);
        settle(60);
        repeat (80) begin
            @(negedge mclk_i);
            n_hi += period_match_irq_o;
            n_pin += pulse_output_pin_o;
        end
        check("irq div4", n_hi, 32'h0000_0008);
        check("pin held", n_pin, 32'h0000_0050);
        set_mode(1'b0, `PWT_CKS_DIV4, 1'b1, 1'b0);
        bus(1'b1, `PWT_ADR_DUTY, 32'h0000_0003);
        set_mode(1'b1, `PWT_CKS_DIV4, 1'b1, 1'b1);
        settle(120);
        check("cycle div4", cyc_len, 32'h0000_0028);
        check("idle high", hi_len, 32'h0000_0018);
    endtask
    task automatic t_clocks;
        // Slow clock period is four system clocks, so one count clock is 512 system clocks.
        set_mode(1'b0, `PWT_CKS_DIV4, 1'b1, 1'b1);
        bus(1'b1, `PWT_ADR_PERIOD, 32'h0000_0001);
        bus(1'b1, `PWT_ADR_DUTY, 32'h0000_0000);
        set_mode(1'b1, `PWT_CKS_RL128, 1'b0, 1'b1);
        settle(2700);
        check("cycle slow", cyc_len, 32'h0000_0400);
        check("active slow", hi_len, 32'h0000_0200);
    endtask
    task automatic give_verdict;
        $display("comparisons %0d err_count %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        repeat (8000) @(posedge mclk_i);
        err_count++;
        give_verdict;
    end
    initial begin
        err_count = 0;
        comparisons = 0;
        rst_n_i = 1'b0;
        wb_cyc_i = 1'b0;
        wb_stb_i = 1'b0;
        wb_we_i = 1'b0;
        wb_adr_i = 8'h00;
        wb_sel_i = 4'h1;
        wb_dat_i = 32'h0000_0000;
        repeat (2) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        t_basic;
        t_duty;
        t_irq;
        t_slow;
        t_clocks;
        give_verdict;
    end
endmodule // test_pwt_timer
